// File: rtl/blrv_pkg.sv
package blrv_pkg;

  localparam int unsigned ADDR_W = 15;

  // APB register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_LOCK   = 12'h004;
  localparam logic [11:0] OFS_FUSE   = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_RSTVEC = 12'h010;

  // Field positions.
  localparam int unsigned LOCK_APP_LO  = 0;
  localparam int unsigned LOCK_APP_HI  = 1;
  localparam int unsigned LOCK_BOOT_LO = 2;
  localparam int unsigned LOCK_BOOT_HI = 3;
  localparam int unsigned CTRL_IVSEL   = 0;
  localparam int unsigned CTRL_ERASE   = 1;
  localparam int unsigned CTRL_LMODE   = 2;

  // Reset values: 1 means unprogrammed.
  localparam logic [3:0] LOCK_RST       = 4'hf;
  localparam logic [1:0] LMODE_RST      = 2'h3;
  localparam logic [1:0] BOOT_SIZE_FUSES_RST     = 2'h0;
  localparam logic [1:0] PROT_FREE      = 2'h3;
  localparam logic [1:0] PROT_NO_WRITE  = 2'h2;
  localparam logic [1:0] PROT_LOCKED    = 2'h0;
  localparam logic [1:0] PROT_NO_READ   = 2'h1;
  localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 15'h0000;
  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] pc;
  } blrv_acc_t;

  typedef struct packed {
    logic grant;
    logic block;
  } blrv_resp_t;

  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_RUN   = 2'b01
  } blrv_state_t;

  // Boot loader start word address for each boot size fuse code.
  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] sz);
    unique case (sz)
      2'b00:   boot_start = 15'h3800;
      2'b01:   boot_start = 15'h3c00;
      2'b10:   boot_start = 15'h3e00;
      default: boot_start = 15'h3f00;
    endcase
  endfunction : boot_start

endpackage : blrv_pkg

// File: rtl/blrv_boot_lock.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
// How it works
// RQ1: Separate two-bit protection fields for application and boot sections.
// RQ2: Software may only program bits; only chip erase restores them. Here a CTRL write with the erase bit set also restores them.
// RQ3: General write lock mode 2 never gates self-programming stores.
// RQ4: General read/write lock mode 1 never gates core loads or stores.
// RQ5: Application field 11 leaves application accesses unrestricted.
// RQ6: Application field 10 blocks stores to application, loads allowed.
// RQ7: Application field 00 blocks stores and boot-code loads of it.
// RQ8: Application modes 00/01 mask interrupts in application if vectors boot.
// RQ9: Boot field 11 leaves boot section accesses unrestricted.
// RQ10: Boot field 10 blocks stores to the boot section.
// RQ11: Boot 00 blocks stores and app loads; 01 blocks only loads.
// RQ12: Boot modes 00/01 mask interrupts in boot if vectors in app.
// RQ13: Boot reset fuse 1 gives vector zero, 0 gives boot address.
// RQ14: Fuses are not writable by core software.
// RQ15: With hardware boot enabled, boot pin is input and caught at release.
// RQ16: Boot pin low at release forces the boot loader address.
// RQ17: Hardware boot enable fuse unprogrammed makes the pin irrelevant.
// RQ18: Stores only program when executed from the boot section.
// RQ19: Boot size fuses set the section boundary and boot address.
// RQ20: Either fuse or pin request selects boot address, else zero.
// RQ21: Blocked accesses change neither flash nor protection fields.
module blrv_boot_lock (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   boot_reset_fuse_i,
  input  wire logic                   hw_boot_enable_fuse_i,
  input  wire logic [1:0]             boot_size_fuses_i,
  input  wire logic                   hw_boot_pin_i,
  output logic                        hw_boot_pin_oe_o,
  input  wire blrv_pkg::blrv_acc_t    acc_i,
  output blrv_pkg::blrv_resp_t        resp_o,
  input  wire logic                   lock_prog_i,
  input  wire logic [3:0]             lock_prog_data_i,
  input  wire logic                   chip_erase_i,
  input  wire logic                   ivec_in_boot_i,
  output logic                        irq_mask_o,
  output logic      [blrv_pkg::ADDR_W-1:0] reset_vector_o
);
  import blrv_pkg::*;

  // Protection state and the next value of every register but the pin synchroniser.
  logic [3:0]        lock_q;
  logic [3:0]        lock_d;
  logic [1:0]        lmode_q;
  logic [1:0]        lmode_d;
  logic [1:0]        pin_sync_q;
  logic              hwb_q;
  logic              hwb_d;
  logic              blocked_q;
  logic              blocked_d;
  blrv_state_t       state_q;
  blrv_state_t       state_d;
  logic [ADDR_W-1:0] vec_q;
  logic [ADDR_W-1:0] vec_d;
  logic [31:0]       rdata;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;

  // Stores pass where the low bit is unprogrammed: free and no-read modes.
  function automatic logic prot_wr_ok(input logic [1:0] field);
    unique case (field)
      PROT_FREE:     prot_wr_ok = 1'b1;
      PROT_NO_WRITE: prot_wr_ok = 1'b0;
      PROT_LOCKED:   prot_wr_ok = 1'b0;
      PROT_NO_READ:  prot_wr_ok = 1'b1;
    endcase
  endfunction : prot_wr_ok

  // Cross-section loads pass in the free and no-write modes only.
  function automatic logic prot_rd_ok(input logic [1:0] field);
    unique case (field)
      PROT_FREE:     prot_rd_ok = 1'b1;
      PROT_NO_WRITE: prot_rd_ok = 1'b1;
      PROT_LOCKED:   prot_rd_ok = 1'b0;
      PROT_NO_READ:  prot_rd_ok = 1'b0;
    endcase
  endfunction : prot_rd_ok

  // Modes that stop cross loads also mask interrupts on the far side.
  function automatic logic prot_irq_lock(input logic [1:0] field);
    unique case (field)
      PROT_FREE:     prot_irq_lock = 1'b0;
      PROT_NO_WRITE: prot_irq_lock = 1'b0;
      PROT_LOCKED:   prot_irq_lock = 1'b1;
      PROT_NO_READ:  prot_irq_lock = 1'b1;
    endcase
  endfunction : prot_irq_lock

  // Section test shared by the target address and the fetch address.
  function automatic logic in_boot(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
    in_boot = a >= base;
  endfunction : in_boot

  // Section fields split out of the lock word.
  wire [1:0] app_prot_field     = {lock_q[LOCK_APP_HI], lock_q[LOCK_APP_LO]};
  wire [1:0] bootsec_prot_field = {lock_q[LOCK_BOOT_HI],
                                   lock_q[LOCK_BOOT_LO]};

  // Section boundary from the boot size fuses.
  wire [ADDR_W-1:0] boot_addr = boot_start(boot_size_fuses_i); // RQ19
  wire tgt_boot = in_boot(acc_i.addr, boot_addr); // RQ19
  wire pc_boot  = in_boot(acc_i.pc, boot_addr); // RQ19
  wire tgt_app  = !tgt_boot;
  wire pc_app   = !pc_boot;

  // Access kind as seen from the core.
  wire is_store   = acc_i.req && acc_i.write;
  wire is_load    = acc_i.req && !acc_i.write;
  wire same_sec   = tgt_boot == pc_boot;
  wire cross_app  = pc_boot && tgt_app;
  wire cross_boot = pc_app && tgt_boot;

  // Store permission ignores the general lock mode entirely.
  wire app_wr_ok  = prot_wr_ok(app_prot_field); // RQ3 RQ4 RQ5 RQ6 RQ7
  wire boot_wr_ok = prot_wr_ok(bootsec_prot_field); // RQ9 RQ10 RQ11
  wire sec_wr_ok  = tgt_boot ? boot_wr_ok : app_wr_ok;
  // Stores issued from application code never program anything.
  wire wr_ok      = pc_boot && sec_wr_ok; // RQ18

  // A load inside its own section is never blocked; only cross loads.
  wire app_rd_ok  = prot_rd_ok(app_prot_field); // RQ5 RQ6 RQ7
  wire boot_rd_ok = prot_rd_ok(bootsec_prot_field); // RQ9 RQ11
  wire x_app_ok   = !cross_app || app_rd_ok; // RQ7
  wire x_boot_ok  = !cross_boot || boot_rd_ok; // RQ11
  wire rd_ok      = same_sec || (x_app_ok && x_boot_ok); // RQ4

  // Grant and block come from the same terms, so exactly one answers a
  // request and neither moves while the core is idle.
  assign resp_o.grant = (is_store && wr_ok) || (is_load && rd_ok); // RQ21
  assign resp_o.block = (is_store && !wr_ok) || (is_load && !rd_ok); // RQ21

  // Interrupts are masked in the section that cannot reach the vectors.
  wire app_irq_lock  = prot_irq_lock(app_prot_field); // RQ8
  wire boot_irq_lock = prot_irq_lock(bootsec_prot_field); // RQ12
  wire irq_app_side  = ivec_in_boot_i && pc_app && app_irq_lock; // RQ8
  wire irq_boot_side = !ivec_in_boot_i && pc_boot && boot_irq_lock; // RQ12
  assign irq_mask_o  = irq_app_side || irq_boot_side;

  // APB decode; zero wait states, so every access phase completes.
  // Unmapped offsets answer with an error rather than stalling the bus.
  wire apb_acc    = psel_i && penable_i;
  wire wr_acc     = apb_acc && pwrite_i;
  wire rd_setup   = psel_i && !penable_i;
  wire hit_ctrl   = paddr_i == OFS_CTRL;
  wire hit_lock   = paddr_i == OFS_LOCK;
  wire hit_fuse   = paddr_i == OFS_FUSE;
  wire hit_status = paddr_i == OFS_STATUS;
  wire hit_rstvec = paddr_i == OFS_RSTVEC;
  wire mapped     = hit_ctrl || hit_lock || hit_fuse || hit_status ||
                    hit_rstvec;
  wire wr_ctrl    = wr_acc && hit_ctrl;
  wire wr_lock    = wr_acc && hit_lock;
  wire sw_erase   = wr_ctrl && pwdata_i[CTRL_ERASE]; // RQ2
  wire any_erase  = chip_erase_i || sw_erase; // RQ2

  // Lock word: bits only move toward zero until an erase.
  wire [3:0] sw_lock_mask   = wr_lock ? pwdata_i[3:0] : LOCK_RST; // RQ2
  wire [3:0] prog_lock_mask = lock_prog_i ? lock_prog_data_i : LOCK_RST;
  wire [3:0] lock_and       = lock_q & sw_lock_mask & prog_lock_mask;

  always_comb begin
    lock_d = lock_and; // RQ2
    if (any_erase) begin
      lock_d = LOCK_RST; // RQ2
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_q <= LOCK_RST;
    end else begin
      lock_q <= lock_d; // RQ1
    end
  end

  // Lock mode is stored and readable but steers no flash access.
  // The erase bit is never stored, so it reads back as zero.
  assign lmode_d = wr_ctrl ? pwdata_i[CTRL_LMODE+1:CTRL_LMODE] : lmode_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lmode_q <= LMODE_RST;
    end else begin
      lmode_q <= lmode_d; // RQ3 RQ4
    end
  end

  // The synchroniser has no reset, so it keeps following the pin while
  // reset is held; the pin must stand for two edges before release.
  always_ff @(posedge sys_clk_i) begin
    pin_sync_q <= {pin_sync_q[0], hw_boot_pin_i}; // RQ15
  end
  wire pin_low = !pin_sync_q[1];

  // Strap decode: fuse request, or pin request when the pin is enabled.
  wire hw_req   = !hw_boot_enable_fuse_i && pin_low; // RQ15 RQ16 RQ17
  wire fuse_req = !boot_reset_fuse_i; // RQ13
  wire boot_req = fuse_req || hw_req; // RQ20
  wire [ADDR_W-1:0] strap_vec = boot_req ? boot_addr : APP_RESET_ADDR;

  // One strap cycle after reset, then the vector stays put until reset.
  always_comb begin
    state_d = state_q;
    hwb_d   = hwb_q;
    vec_d   = vec_q;
    unique case (state_q)
      ST_STRAP: begin
        state_d = ST_RUN;
        hwb_d   = hw_req; // RQ16
        vec_d   = strap_vec; // RQ13 RQ20
      end
      ST_RUN: begin
        state_d = ST_RUN; // RQ14
      end
      default: begin
        state_d = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // The taken flag lets software tell a pin boot from a fuse boot.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hwb_q <= 1'b0;
    end else begin
      hwb_q <= hwb_d;
    end
  end

  // Fuses may move under reset only, so the vector is caught once.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vec_q <= APP_RESET_ADDR;
    end else begin
      vec_q <= vec_d;
    end
  end

  // Pin is never driven by this block.
  assign hw_boot_pin_oe_o = 1'b0; // RQ15
  assign reset_vector_o   = vec_q;

  // Sticky block flag; a block in the same cycle as a clear wins.
  always_comb begin
    blocked_d = blocked_q;
    if (wr_ctrl) begin
      blocked_d = 1'b0;
    end
    if (resp_o.block) begin
      blocked_d = 1'b1; // RQ21
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blocked_q <= 1'b0;
    end else begin
      blocked_q <= blocked_d;
    end
  end

  // Fuse register is read-only; writes to it are dropped.
  wire [31:0] rd_lock   = {28'h0, lock_q};
  wire [31:0] rd_fuse   = {28'h0, boot_size_fuses_i, hw_boot_enable_fuse_i,
                           boot_reset_fuse_i}; // RQ14
  wire [31:0] rd_status = {29'h0, pin_sync_q[1], hwb_q, blocked_q};
  wire [31:0] rd_rstvec = {17'h0, vec_q};

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr_i)
      OFS_CTRL: begin
        rdata[CTRL_LMODE+1:CTRL_LMODE] = lmode_q;
      end
      OFS_LOCK: begin
        rdata = rd_lock;
      end
      OFS_FUSE: begin
        rdata = rd_fuse;
      end
      OFS_STATUS: begin
        rdata = rd_status;
      end
      OFS_RSTVEC: begin
        rdata = rd_rstvec;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is caught in the setup cycle, so the access phase reads a
  // flop; a value that moves during the access phase is shown late.
  assign prdata_d = rd_setup ? rdata : prdata_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && !mapped;

endmodule : blrv_boot_lock

// File: dv/blrv_boot_lock_monitor.sv
`timescale 1ns/100ps
module blrv_boot_lock_monitor (
  input wire logic sys_clk_i, reset_n_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic boot_reset_fuse_i, hw_boot_enable_fuse_i, hw_boot_pin_i,
  input wire logic hw_boot_pin_oe_o, lock_prog_i, chip_erase_i,
  input wire logic [3:0] lock_prog_data_i,
  input wire logic ivec_in_boot_i, irq_mask_o,
  input wire blrv_pkg::blrv_acc_t acc_i,
  input wire blrv_pkg::blrv_resp_t resp_o,
  input wire logic [14:0] reset_vector_o
);
  import blrv_pkg::*;
  logic [3:0] lock_q;
  logic run_q, pin_q;
  wire ap = psel_i && penable_i && pwrite_i;
  wire er = chip_erase_i || (ap && paddr_i == OFS_CTRL && pwdata_i[1]);
  wire [14:0] bs = 15'h4000 - (15'h0800 >> boot_size_fuses_i);
  wire pb = acc_i.pc >= bs;
  wire ab = acc_i.addr >= bs;
  wire bt = !boot_reset_fuse_i || !(hw_boot_enable_fuse_i || pin_q);
  wire [3:0] lp = lock_prog_i ? lock_prog_data_i : 4'hf;
  wire [3:0] lw = ap && paddr_i == OFS_LOCK ? pwdata_i[3:0] : 4'hf;
  // A shadow of the lock bits lets every store and cross-section load grant be judged at once.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i) {lock_q, run_q, pin_q} <= 6'h3d;
    else {lock_q, run_q, pin_q} <= {er ? 4'hf : lock_q & lp & lw, 1'b1,
                                    run_q ? pin_q : hw_boot_pin_i};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_PIN_IN: assert property (!hw_boot_pin_oe_o)
    else $error("boot pin driven");
  AST_VEC_HOLD: assert property (run_q |=> $stable(reset_vector_o))
    else $error("vector moved");
  AST_VEC_SEL: assert property (run_q |->
    reset_vector_o == (bt ? bs : 15'h0000)) else $error("wrong vector");
  AST_APP_STORE: assert property (acc_i.req && acc_i.write && pb && !ab
    |-> resp_o.grant == lock_q[0]) else $error("app store");
  AST_BOOT_STORE: assert property (acc_i.req && acc_i.write && pb && ab
    |-> resp_o.grant == lock_q[2]) else $error("boot store");
  AST_APP_PC: assert property (acc_i.req && acc_i.write && !pb
    |-> !resp_o.grant && resp_o.block) else $error("store from app");
  AST_X_LOAD: assert property (acc_i.req && !acc_i.write && pb != ab
    |-> resp_o.grant == lock_q[ab ? 3 : 1]) else $error("cross load");
  AST_IRQ: assert property (acc_i.req |-> irq_mask_o == (pb ?
    !ivec_in_boot_i && !lock_q[3] : ivec_in_boot_i && !lock_q[1]))
    else $error("irq mask");
endmodule : blrv_boot_lock_monitor
bind blrv_boot_lock blrv_boot_lock_monitor u_mon (.*);

// File: dv/blrv_core_model.sv
`timescale 1ns/100ps
module blrv_core_model (
  input  wire logic                sys_clk_i,
  input  wire logic                op_valid_i,
  input  wire blrv_pkg::blrv_acc_t op_i,
  output blrv_pkg::blrv_acc_t      acc_o
);
  import blrv_pkg::*;
  // An idle bus shows inverted addresses, so nothing leans on stale values.
  always_ff @(posedge sys_clk_i)
    acc_o <= op_valid_i ? op_i : '{1'b0, 1'b0, ~acc_o.addr, ~acc_o.pc};
endmodule : blrv_core_model

// File: dv/blrv_boot_lock_tb.sv
`timescale 1ns/100ps
module blrv_boot_lock_tb;
  import blrv_pkg::*;
  logic sys_clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic boot_reset_fuse_i = 1, hw_boot_enable_fuse_i = 1, hw_boot_pin_i = 1;
  logic lock_prog_i = 0, chip_erase_i = 0, ivec_in_boot_i = 0, opv = 0;
  logic pready_o, pslverr_o, hw_boot_pin_oe_o, irq_mask_o;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [1:0] boot_size_fuses_i = '0;
  logic [3:0] lock_prog_data_i = '0;
  logic [14:0] reset_vector_o;
  blrv_acc_t op = '0, acc_i;
  blrv_resp_t resp_o;
  logic [64:0] rq[$];
  logic gq[$];
  int bad_count = 0, compares = 0, seed = 22245;
  always #10 sys_clk_i = ~sys_clk_i;
  blrv_core_model u_core (.sys_clk_i, .op_valid_i(opv), .op_i(op),
                          .acc_o(acc_i));
  blrv_boot_lock DUT (.*);
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [64:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [14:0] bst(input logic [1:0] s);
    return 15'h4000 - (15'h0800 >> s);
  endfunction : bst
  function automatic logic [14:0] pick(input logic b);
    int unsigned r = $random(seed);
    logic [14:0] s = bst(boot_size_fuses_i);
    return b ? s + 15'(r % (15'h4000 - s)) : 15'(r % s);
  endfunction : pick
  always @(posedge sys_clk_i) begin
    if (acc_i.req === 1'b1) cmp(resp_o.grant, gq.pop_front());
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      cmp({pslverr_o, rq[0][63:32], prdata_o & rq[0][63:32]}, rq[0]);
      void'(rq.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic x);
    rq.push_back({x, m, e & m});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic strobe(input logic p, input logic [3:0] d);
    @(posedge sys_clk_i);
    {lock_prog_i, chip_erase_i, lock_prog_data_i} <= {p, !p, d};
    @(posedge sys_clk_i);
    {lock_prog_i, chip_erase_i} <= 2'b00;
  endtask : strobe
  task automatic core(input logic w, pb, ab, g);
    @(posedge sys_clk_i);
    opv <= 1'b1;
    op <= '{1'b1, w, pick(ab), pick(pb)};
    ivec_in_boot_i <= 1'($random(seed));
    gq.push_back(g);
    @(posedge sys_clk_i);
    opv <= 1'b0;
  endtask : core
  task automatic boot(input logic [4:0] c);
    logic [14:0] v = c[4] && (c[3] || c[2]) ? 15'h0 : bst(c[1:0]);
    reset_n_i <= 1'b0;
    {boot_reset_fuse_i, hw_boot_enable_fuse_i, hw_boot_pin_i} <= c[4:2];
    boot_size_fuses_i <= c[1:0];
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    cmp(reset_vector_o, v);
    rd(OFS_RSTVEC, {17'h0, v}, 32'h7fff, 1'b0);
    rd(OFS_STATUS, {29'h0, c[2], !c[3] && !c[2], 1'b0}, 32'h7, 1'b0);
    hw_boot_pin_i <= ~c[2];
    apb(1'b1, OFS_FUSE, 32'h0);
    rd(OFS_FUSE, {28'h0, c[1:0], c[3], c[4]}, 32'hf, 1'b0);
  endtask : boot
  task automatic locks(input logic [3:0] v);
    logic [31:0] m = 32'($random(seed)) & 32'hc;
    apb(1'b1, OFS_CTRL, m);
    rd(OFS_CTRL, m, 32'hf, 1'b0);
    rd(OFS_STATUS, 32'h0, 32'h1, 1'b0);
    if (v[2]) apb(1'b1, OFS_CTRL, 32'h2);
    else strobe(1'b0, 4'h0);
    if (v[1]) apb(1'b1, OFS_LOCK, {28'hfffffff, v});
    else strobe(1'b1, v);
    apb(1'b1, OFS_LOCK, 32'hf);
    rd(OFS_LOCK, {28'h0, v}, 32'hf, 1'b0);
    core(1'b1, 1'b1, 1'b0, v[0]);
    core(1'b1, 1'b1, 1'b1, v[2]);
    core(1'b1, 1'b0, 1'b0, 1'b0);
    core(1'b0, 1'b1, 1'b0, v[1]);
    core(1'b0, 1'b0, 1'b1, v[3]);
    core(1'b0, 1'b0, 1'b0, 1'b1);
    core(1'b0, 1'b1, 1'b1, 1'b1);
    rd(OFS_STATUS, 32'h1, 32'h1, 1'b0);
    rd(12'h014, 32'h0, 32'h0, 1'b1);
  endtask : locks
  initial begin
    for (int i = 0; i < 8; i++) begin
      boot({3'(i), 2'(i)});
      locks(4'(2 * i));
      locks(4'(2 * i + 1));
      $display("test %0d done", i);
    end
    complete_run();
  end
  // A hung handshake must still reach the verdict.
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    bad_count++;
    complete_run();
  end
endmodule : blrv_boot_lock_tb
